// ### core/i2c_fn_defs.svh
// named constants for the two-wire function access link
// assumes a 50 MHz reference clock on both ends
`ifndef I2C_FN_DEFS_SVH
`define I2C_FN_DEFS_SVH
`define DEV_ADDR 7'h2e
// internal register indices
`define RA_FIFO 8'h00
`define RA_CNT 8'h01
`define RA_CTRL 8'h02
`define RA_STAT 8'h03
`define RA_FLAG 8'h04
`define RA_MASK 8'h05
`define RA_LINK 8'h06
// field positions, fifo depth and divided clock half period
`define CTRL_CLR 0
`define STAT_ACK 0
`define STAT_OVR 1
`define STAT_ARM 2
`define FLAG_EPTX 0
`define FLAG_SUSP 1
`define FIFO_DEPTH 4'h8
`define DCLK_HALF_PERIOD 2'h2
// serial timing
`define REF_NS 20
`define SCL_BIT_NS 2500
`define QTR_CYCLES ((`SCL_BIT_NS + 4 * `REF_NS - 1) / (4 * `REF_NS))
// controller apb map
`define APB_CMD 12'h000
`define APB_WDATA 12'h004
`define APB_RDATA 12'h008
`define APB_STAT 12'h00c
`define CMD_RD 8
`define CMD_LEN_LO 9
`define ST_BUSY 0
`define ST_NACK 1
`endif

// ### core/i2c_fn_pkg.sv
// state types of both link ends
// assumes nothing beyond the standard language
package i2c_fn_pkg;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_RX_ACK, D_TX, D_TX_ACK, D_IGNORE} dev_st_t;
  typedef enum logic [2:0] {C_IDLE, C_START, C_SEND, C_RECV, C_STOP} ctl_st_t;
  typedef enum logic [2:0] {S_DEVW, S_SUB, S_WDATA, S_DEVR, S_RDATA} stage_t;
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, wake_m, wake_s;
    dev_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first, have_sub, rd, wrote, oe;
    logic [7:0] sub;
    logic [7:0][7:0] mem;
    logic [2:0] wp, rp;
    logic [3:0] lvl, cnt_reg;
    logic clr, armed, ack_f, ovr_f, ep_f, sus_f, sus_pend, suspended;
    logic [1:0] mask, div;
    logic irq, clk_o, wake;
    logic [7:0] txd;
  } dev_state_t;
  typedef struct packed {
    logic sda_m, sda_s;
    ctl_st_t st;
    stage_t stage;
    logic [1:0] q;
    logic [5:0] qc;
    logic [3:0] bitn;
    logic [7:0] sh, sub;
    logic [1:0] idx, len;
    logic rd, busy, err, scl, oe;
    logic [31:0] wdata, rdata, prdata;
    logic pready, pslverr;
  } ctl_state_t;
endpackage : i2c_fn_pkg

// ### core/i2c_fn_if.sv
// two-wire link between controller and function device
// resolves the open-drain data wire from both enables
`timescale 1ns/100ps
`default_nettype none
interface i2c_fn_if;
  logic scl;
  logic sda_ctl_out, sda_ctl_oe, sda_dev_out, sda_dev_oe;
  logic sda;
  // wired-and with pull-up
  assign sda = ~((sda_ctl_oe & ~sda_ctl_out) | (sda_dev_oe & ~sda_dev_out));
  modport controller (output scl, output sda_ctl_out, output sda_ctl_oe, input sda);
  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe);
endinterface : i2c_fn_if
`default_nettype wire

// ### core/i2c_fn_device.sv
// serial slave end of the function: registers, tx fifo, suspend
// assumes scl and sda from a foreign domain, usb side on ref clock
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_fn_defs.svh"
module i2c_fn_device (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  i2c_fn_if.device link,
  input wire logic wakeup_in,
  input wire logic function_enabled_in,
  input wire logic suspend_evt_in,
  input wire logic resume_in,
  input wire logic in_ack_in,
  input wire logic tx_pop_in,
  output logic irq_out,
  output logic suspend_out,
  output logic divided_clock_out,
  output logic remote_wake_out,
  output logic [7:0] tx_data_out
);
  i2c_fn_pkg::dev_state_t s_ff, nxt_s;
  logic scl_rise, scl_fall, start_c, stop_c, match;

  function automatic logic [7:0] rd_mux(input i2c_fn_pkg::dev_state_t s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `RA_CNT: r = {4'h0, s.cnt_reg};
      `RA_CTRL: r[`CTRL_CLR] = s.clr;
      `RA_STAT: r = {5'h00, s.armed, s.ovr_f, s.ack_f};
      `RA_FLAG: r = {6'h00, s.sus_f, s.ep_f};
      `RA_MASK: r = {6'h00, s.mask};
      `RA_LINK: r = {3'h0, s.suspended, s.lvl};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_mux

  assign scl_rise = s_ff.scl_s & ~s_ff.scl_p;
  assign scl_fall = ~s_ff.scl_s & s_ff.scl_p;
  assign start_c = s_ff.scl_s & s_ff.scl_p & s_ff.sda_p & ~s_ff.sda_s;
  assign stop_c = s_ff.scl_s & s_ff.scl_p & ~s_ff.sda_p & s_ff.sda_s;
  assign match = s_ff.sh[7:1] == `DEV_ADDR;

  always_comb begin
    logic ack, sus_clr;
    ack = 1'b0;
    sus_clr = 1'b0;
    nxt_s = s_ff;
    // two-flop synchronisers, sampled fast enough for 400 kbps
    nxt_s.scl_m = link.scl;
    nxt_s.scl_s = s_ff.scl_m;
    nxt_s.scl_p = s_ff.scl_s;
    nxt_s.sda_m = link.sda;
    nxt_s.sda_s = s_ff.sda_m;
    nxt_s.sda_p = s_ff.sda_s;
    nxt_s.wake_m = wakeup_in;
    nxt_s.wake_s = s_ff.wake_m;
    // usb side drains the fifo
    if (tx_pop_in && s_ff.lvl != 4'h0) begin
      nxt_s.txd = s_ff.mem[s_ff.rp];
      nxt_s.rp = s_ff.rp + 3'h1;
      nxt_s.lvl = s_ff.lvl - 4'h1;
    end
    if (s_ff.clr) begin
      nxt_s.wp = 3'h0;
      nxt_s.rp = 3'h0;
      nxt_s.lvl = 4'h0;
      nxt_s.clr = 1'b0;
    end
    if (stop_c) begin
      nxt_s.st = i2c_fn_pkg::D_IDLE;
      nxt_s.oe = 1'b0;
      nxt_s.have_sub = 1'b0;
    end else if (start_c) begin
      nxt_s.st = i2c_fn_pkg::D_RX;
      nxt_s.cnt = 4'h0;
      nxt_s.first = 1'b1;
      nxt_s.wrote = 1'b0;
      nxt_s.oe = 1'b0;
    end else begin
      unique case (s_ff.st)
        i2c_fn_pkg::D_IDLE, i2c_fn_pkg::D_IGNORE: nxt_s.oe = 1'b0;
        i2c_fn_pkg::D_RX: begin
          if (scl_rise && s_ff.cnt != 4'h8) begin
            nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_s};
            nxt_s.cnt = s_ff.cnt + 4'h1;
          end else if (scl_fall && s_ff.cnt == 4'h8) begin
            if (s_ff.first) begin
              ack = match;
              nxt_s.rd = s_ff.sh[0];
            end else if (!s_ff.have_sub) begin
              ack = 1'b1;
              nxt_s.sub = s_ff.sh;
              nxt_s.have_sub = 1'b1;
            end else begin
              ack = 1'b1;
              unique case (s_ff.sub)
                `RA_FIFO: begin
                  if (nxt_s.lvl == `FIFO_DEPTH) begin
                    ack = 1'b0;
                    nxt_s.ovr_f = 1'b1;
                    nxt_s.ep_f = 1'b1;
                  end else begin
                    nxt_s.mem[nxt_s.wp] = s_ff.sh;
                    nxt_s.wp = nxt_s.wp + 3'h1;
                    nxt_s.lvl = nxt_s.lvl + 4'h1;
                  end
                end
                default: begin
                  if (s_ff.wrote) begin
                    ack = 1'b0;
                  end else begin
                    unique case (s_ff.sub)
                      `RA_CNT: begin
                        nxt_s.cnt_reg = s_ff.sh[3:0];
                        nxt_s.armed = 1'b1;
                      end
                      `RA_CTRL: nxt_s.clr = s_ff.clr | s_ff.sh[`CTRL_CLR];
                      `RA_STAT: begin
                        if (s_ff.sh[`STAT_ACK]) begin
                          nxt_s.ack_f = 1'b0;
                          nxt_s.ep_f = 1'b0;
                        end
                        if (s_ff.sh[`STAT_OVR]) begin
                          nxt_s.ovr_f = 1'b0;
                          nxt_s.ep_f = 1'b0;
                        end
                      end
                      `RA_FLAG: begin
                        if (s_ff.sh[`FLAG_EPTX]) nxt_s.ep_f = 1'b0;
                        if (s_ff.sh[`FLAG_SUSP]) begin
                          nxt_s.sus_f = 1'b0;
                          sus_clr = 1'b1;
                        end
                      end
                      `RA_MASK: nxt_s.mask = s_ff.sh[1:0];
                      default: ack = 1'b0;
                    endcase
                    nxt_s.wrote = 1'b1;
                  end
                end
              endcase
            end
            nxt_s.oe = ack;
            nxt_s.st = ack ? i2c_fn_pkg::D_RX_ACK : i2c_fn_pkg::D_IGNORE;
          end
        end
        i2c_fn_pkg::D_RX_ACK: begin
          if (scl_fall) begin
            nxt_s.first = 1'b0;
            nxt_s.cnt = 4'h0;
            if (s_ff.first && s_ff.rd) begin
              nxt_s.sh = rd_mux(s_ff, s_ff.sub);
              nxt_s.oe = ~nxt_s.sh[7];
              nxt_s.st = i2c_fn_pkg::D_TX;
            end else begin
              nxt_s.oe = 1'b0;
              nxt_s.st = i2c_fn_pkg::D_RX;
            end
          end
        end
        i2c_fn_pkg::D_TX: begin
          if (scl_fall) begin
            nxt_s.cnt = s_ff.cnt + 4'h1;
            if (s_ff.cnt == 4'h7) begin
              nxt_s.oe = 1'b0;
              nxt_s.st = i2c_fn_pkg::D_TX_ACK;
            end else begin
              nxt_s.sh = {s_ff.sh[6:0], 1'b0};
              nxt_s.oe = ~s_ff.sh[6];
            end
          end
        end
        i2c_fn_pkg::D_TX_ACK: begin
          if (scl_rise) begin
            nxt_s.rd = ~s_ff.sda_s;
          end else if (scl_fall) begin
            nxt_s.cnt = 4'h0;
            if (s_ff.rd) begin
              nxt_s.sh = rd_mux(s_ff, s_ff.sub);
              nxt_s.oe = ~nxt_s.sh[7];
              nxt_s.st = i2c_fn_pkg::D_TX;
            end else begin
              nxt_s.st = i2c_fn_pkg::D_IGNORE;
            end
          end
        end
        default: nxt_s.st = i2c_fn_pkg::D_IDLE;
      endcase
    end
    // hardware sets come after software clears so a set wins
    if (in_ack_in && s_ff.armed) begin
      nxt_s.ack_f = 1'b1;
      nxt_s.ep_f = 1'b1;
      nxt_s.armed = 1'b0;
    end
    if (suspend_evt_in) begin
      nxt_s.sus_f = 1'b1;
      nxt_s.sus_pend = 1'b1;
    end else if (sus_clr && s_ff.sus_pend) begin
      nxt_s.suspended = 1'b1;
      nxt_s.sus_pend = 1'b0;
    end
    nxt_s.wake = s_ff.wake_s & function_enabled_in;
    if (s_ff.wake || resume_in) nxt_s.suspended = 1'b0;
    nxt_s.irq = |({nxt_s.sus_f, nxt_s.ep_f} & s_ff.mask);
    // clock output stops in low power
    if (s_ff.suspended) begin
      nxt_s.clk_o = 1'b0;
      nxt_s.div = 2'h0;
    end else if (s_ff.div == `DCLK_HALF_PERIOD - 2'h1) begin
      nxt_s.div = 2'h0;
      nxt_s.clk_o = ~s_ff.clk_o;
    end else begin
      nxt_s.div = s_ff.div + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_ff <= '0;
      s_ff.scl_m <= 1'b1;
      s_ff.scl_s <= 1'b1;
      s_ff.scl_p <= 1'b1;
      s_ff.sda_m <= 1'b1;
      s_ff.sda_s <= 1'b1;
      s_ff.sda_p <= 1'b1;
      s_ff.st <= i2c_fn_pkg::D_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = s_ff.oe;
  assign irq_out = s_ff.irq;
  assign suspend_out = s_ff.suspended;
  assign divided_clock_out = s_ff.clk_o;
  assign remote_wake_out = s_ff.wake;
  assign tx_data_out = s_ff.txd;
endmodule : i2c_fn_device
`default_nettype wire

// ### core/i2c_fn_ctl.sv
// two-wire master end, commanded over an apb slave port
// assumes the device answers on the shared open-drain wire
`timescale 1ns/100ps
`default_nettype none
`include "i2c_fn_defs.svh"
module i2c_fn_ctl (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  i2c_fn_if.controller link,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  i2c_fn_pkg::ctl_state_t s_ff, nxt_s;
  logic tick, last;

  assign tick = s_ff.busy && s_ff.qc == 6'(`QTR_CYCLES - 1);
  assign last = s_ff.idx == s_ff.len;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sda_m = link.sda;
    nxt_s.sda_s = s_ff.sda_m;
    // apb: setup cycle prepares the answer, access cycle completes
    if (psel_in && !penable_in) begin
      nxt_s.pready = 1'b1;
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata = 32'h0000_0000;
      unique case (paddr_in)
        `APB_CMD: nxt_s.pslverr = s_ff.busy;
        `APB_WDATA: nxt_s.prdata = s_ff.wdata;
        `APB_RDATA: nxt_s.prdata = s_ff.rdata;
        `APB_STAT: nxt_s.prdata = {30'h0000_0000, s_ff.err, s_ff.busy};
        default: nxt_s.pslverr = 1'b1;
      endcase
    end else if (psel_in && penable_in && s_ff.pready) begin
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
      if (pwrite_in && !s_ff.pslverr) begin
        if (paddr_in == `APB_WDATA) nxt_s.wdata = pwdata_in;
        if (paddr_in == `APB_CMD) begin
          nxt_s.sub = pwdata_in[7:0];
          nxt_s.rd = pwdata_in[`CMD_RD];
          nxt_s.len = pwdata_in[`CMD_LEN_LO +: 2];
          nxt_s.busy = 1'b1;
          nxt_s.err = 1'b0;
          nxt_s.idx = 2'h0;
          nxt_s.q = 2'h0;
          nxt_s.qc = 6'h00;
          nxt_s.stage = i2c_fn_pkg::S_DEVW;
          nxt_s.st = i2c_fn_pkg::C_START;
        end
      end
    end
    if (s_ff.busy) nxt_s.qc = tick ? 6'h00 : s_ff.qc + 6'h01;
    if (tick) begin
      nxt_s.q = s_ff.q + 2'h1;
      unique case (s_ff.st)
        i2c_fn_pkg::C_START: begin
          unique case (s_ff.q)
            2'h0: nxt_s.oe = 1'b0;
            2'h1: nxt_s.scl = 1'b1;
            2'h2: nxt_s.oe = 1'b1;
            default: begin
              nxt_s.scl = 1'b0;
              nxt_s.bitn = 4'h0;
              nxt_s.st = i2c_fn_pkg::C_SEND;
              nxt_s.sh = {`DEV_ADDR, s_ff.stage == i2c_fn_pkg::S_DEVR};
            end
          endcase
        end
        i2c_fn_pkg::C_SEND, i2c_fn_pkg::C_RECV: begin
          unique case (s_ff.q)
            // data moves only while scl is low
            2'h0: begin
              if (s_ff.st == i2c_fn_pkg::C_SEND) begin
                nxt_s.oe = s_ff.bitn != 4'h8 && !s_ff.sh[7];
              end else begin
                nxt_s.oe = s_ff.bitn == 4'h8 && !last;
              end
            end
            2'h1: nxt_s.scl = 1'b1;
            2'h2: begin
              if (s_ff.bitn == 4'h8) nxt_s.err = s_ff.st == i2c_fn_pkg::C_SEND && s_ff.sda_s;
              else if (s_ff.st == i2c_fn_pkg::C_RECV) nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_s};
            end
            default: begin
              nxt_s.scl = 1'b0;
              nxt_s.bitn = s_ff.bitn + 4'h1;
              if (s_ff.st == i2c_fn_pkg::C_SEND && s_ff.bitn != 4'h8) nxt_s.sh = {s_ff.sh[6:0], 1'b0};
              if (s_ff.bitn == 4'h8) begin
                nxt_s.bitn = 4'h0;
                if (s_ff.err) begin
                  nxt_s.st = i2c_fn_pkg::C_STOP;
                end else begin
                  unique case (s_ff.stage)
                    i2c_fn_pkg::S_DEVW: begin
                      nxt_s.stage = i2c_fn_pkg::S_SUB;
                      nxt_s.sh = s_ff.sub;
                    end
                    i2c_fn_pkg::S_SUB, i2c_fn_pkg::S_WDATA: begin
                      if (s_ff.rd) begin
                        nxt_s.stage = i2c_fn_pkg::S_DEVR;
                        nxt_s.st = i2c_fn_pkg::C_START;
                      end else if (s_ff.stage == i2c_fn_pkg::S_WDATA && last) begin
                        nxt_s.st = i2c_fn_pkg::C_STOP;
                      end else begin
                        if (s_ff.stage == i2c_fn_pkg::S_WDATA) nxt_s.idx = s_ff.idx + 2'h1;
                        nxt_s.stage = i2c_fn_pkg::S_WDATA;
                        nxt_s.sh = s_ff.wdata[{nxt_s.idx, 3'b000} +: 8];
                      end
                    end
                    i2c_fn_pkg::S_DEVR: begin
                      nxt_s.stage = i2c_fn_pkg::S_RDATA;
                      nxt_s.st = i2c_fn_pkg::C_RECV;
                    end
                    default: begin
                      nxt_s.rdata[{s_ff.idx, 3'b000} +: 8] = s_ff.sh;
                      nxt_s.idx = s_ff.idx + 2'h1;
                      if (last) nxt_s.st = i2c_fn_pkg::C_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
        i2c_fn_pkg::C_STOP: begin
          unique case (s_ff.q)
            2'h0: nxt_s.oe = 1'b1;
            2'h1: nxt_s.scl = 1'b1;
            2'h2: nxt_s.oe = 1'b0;
            default: begin
              nxt_s.busy = 1'b0;
              nxt_s.st = i2c_fn_pkg::C_IDLE;
            end
          endcase
        end
        default: nxt_s.st = i2c_fn_pkg::C_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_ff <= '0;
      s_ff.sda_m <= 1'b1;
      s_ff.sda_s <= 1'b1;
      s_ff.scl <= 1'b1;
      s_ff.st <= i2c_fn_pkg::C_IDLE;
      s_ff.stage <= i2c_fn_pkg::S_DEVW;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.scl = s_ff.scl;
  assign link.sda_ctl_out = 1'b0;
  assign link.sda_ctl_oe = s_ff.oe;
  assign prdata_out = s_ff.prdata;
  assign pready_out = s_ff.pready;
  assign pslverr_out = s_ff.pslverr;
endmodule : i2c_fn_ctl
`default_nettype wire

// ### tb/i2c_fn_link_chk.sv
// link checker: framing, acknowledge slots and refusals on the shared wire
// assumes both ends on one reference clock, signals taken from i2c_fn_if
`timescale 1ns/100ps
`default_nettype none
module i2c_fn_link_chk (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_ctl_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe
);
  typedef struct packed {
    logic scl_q, sda_q, rd, nak;
    logic [3:0] bitc;
    logic [2:0] bytec;
    logic [7:0] sh, sub;
  } mon_t;
  mon_t mon_ff, nxt_mon;
  logic rise, start, stop, ack;
  assign rise = scl & ~mon_ff.scl_q;
  assign start = scl & mon_ff.scl_q & mon_ff.sda_q & ~sda;
  assign stop = scl & mon_ff.scl_q & ~mon_ff.sda_q & sda;
  assign ack = rise & (mon_ff.bitc == 4'h8);
  // bit and byte position since the last start or stop
  always_comb begin
    nxt_mon = mon_ff;
    nxt_mon.scl_q = scl;
    nxt_mon.sda_q = sda;
    if (start || stop) begin
      nxt_mon.bitc = 4'h0;
      nxt_mon.bytec = 3'h0;
      nxt_mon.rd = 1'b0;
      nxt_mon.nak = 1'b0;
    end else if (ack) begin
      nxt_mon.bitc = 4'h0;
      // a not-acknowledge ends the data; the stop that follows releases sda high while scl is high
      nxt_mon.nak = mon_ff.nak | sda;
      if (mon_ff.bytec != 3'h7) nxt_mon.bytec = mon_ff.bytec + 3'h1;
    end else if (rise) begin
      nxt_mon.bitc = mon_ff.bitc + 4'h1;
      nxt_mon.sh = {mon_ff.sh[6:0], sda};
      if (mon_ff.bitc == 4'h7 && mon_ff.bytec == 3'h0) nxt_mon.rd = sda;
      if (mon_ff.bitc == 4'h7 && mon_ff.bytec == 3'h1 && !mon_ff.rd) nxt_mon.sub = {mon_ff.sh[6:0], sda};
    end
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) mon_ff <= '{scl_q: 1'b1, sda_q: 1'b1, default: '0};
    else mon_ff <= nxt_mon;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  open_drain_a: assert property (sda_dev_out == 1'b0)
    else $error("device drives sda high");
  dev_steady_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device changed sda while scl high");
  addr_ack_a: assert property (ack && mon_ff.bytec == 3'h0 |-> sda_dev_oe == (mon_ff.sh[7:1] == 7'h2e))
    else $error("address acknowledge wrong");
  wr_slot_a: assert property (rise && mon_ff.bitc != 4'h8 && !mon_ff.rd |-> !sda_dev_oe)
    else $error("device drove sda outside acknowledge slot");
  reg_single_a: assert property (ack && !mon_ff.rd && mon_ff.bytec >= 3'h3 && mon_ff.sub != 8'h00 |-> !sda_dev_oe)
    else $error("second register byte acknowledged");
  rd_release_a: assert property (ack && mon_ff.rd && mon_ff.bytec != 3'h0 |-> !sda_dev_oe)
    else $error("device held sda in master acknowledge slot");
  nack_stop_a: assert property (ack && sda |-> ##[1:400] stop)
    else $error("no stop after not-acknowledge");
  start_free_a: assert property (start |-> !sda_dev_oe)
    else $error("device drove sda at start");
  ctl_release_a: assert property (ack && !mon_ff.rd |-> !sda_ctl_oe)
    else $error("master drove sda in acknowledge slot");
  rd_bits_a: assert property (rise && mon_ff.rd && !mon_ff.nak && mon_ff.bitc != 4'h8 |-> !sda_ctl_oe)
    else $error("master drove sda during read data");
endmodule : i2c_fn_link_chk
`default_nettype wire

// ### tb/tb.sv
// bench: apb-commanded controller talking to the function device
// assumes the apb map and device register map of the controller and device
`timescale 1ns/100ps
`default_nettype none
`include "i2c_fn_defs.svh"
module tb;
  typedef struct packed {
    logic rd;
    logic [7:0] sub;
    logic [1:0] len;
    logic [31:0] wdata;
    logic nack;
    logic [7:0] rdata;
  } row_t;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, nk;
  logic wakeup = 1'b0, fen = 1'b0, susp_evt = 1'b0, resume = 1'b0, in_ack = 1'b0, pop = 1'b0;
  logic irq, susp_out, dclk, rwake;
  logic [7:0] txd;
  int num_errors = 0;
  int tests_run = 0;
  row_t rows [8];
  always #10 ref_clk_in = ~ref_clk_in;
  i2c_fn_if i_i2c_fn_if ();
  i2c_fn_ctl i_i2c_fn_ctl (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .link(i_i2c_fn_if),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
  i2c_fn_device i_i2c_fn_device (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .link(i_i2c_fn_if),
    .wakeup_in(wakeup), .function_enabled_in(fen), .suspend_evt_in(susp_evt), .resume_in(resume),
    .in_ack_in(in_ack), .tx_pop_in(pop), .irq_out(irq), .suspend_out(susp_out),
    .divided_clock_out(dclk), .remote_wake_out(rwake), .tx_data_out(txd));
  i2c_fn_link_chk i_i2c_fn_link_chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .scl(i_i2c_fn_if.scl),
    .sda(i_i2c_fn_if.sda), .sda_ctl_oe(i_i2c_fn_if.sda_ctl_oe), .sda_dev_out(i_i2c_fn_if.sda_dev_out),
    .sda_dev_oe(i_i2c_fn_if.sda_dev_oe));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      report_and_stop();
    end
    rv = prdata;
    nk = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `APB_STAT, 32'h0000_0000);
      n++;
    end while (rv[0] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_idle
  // one serial transfer; leaves nack flag in nk and the read data word in rv, first read byte in rv[7:0]
  task automatic xfer(input logic rd, input logic [7:0] sub, input logic [1:0] len, input logic [31:0] d);
    logic k;
    apb(1'b1, `APB_WDATA, d);
    apb(1'b1, `APB_CMD, {21'h0, len, rd, sub});
    chk(nk, 1'b0);
    wait_idle();
    k = rv[1];
    apb(1'b0, `APB_RDATA, 32'h0000_0000);
    nk = k;
  endtask : xfer
  // one-cycle strobe on the usb-side events: {suspend, host ack, pop}
  task automatic pulse(input logic [2:0] which);
    @(posedge ref_clk_in) {susp_evt, in_ack, pop} <= which;
    @(posedge ref_clk_in) {susp_evt, in_ack, pop} <= 3'h0;
    repeat (3) @(posedge ref_clk_in);
  endtask : pulse
  initial begin
    rows = '{
      '{1'b0, 8'h05, 2'h0, 32'h0000_0003, 1'b0, 8'h00},
      '{1'b1, 8'h05, 2'h0, 32'h0000_0000, 1'b0, 8'h03},
      '{1'b0, 8'h00, 2'h3, 32'h4433_2211, 1'b0, 8'h00},
      '{1'b0, 8'h01, 2'h0, 32'h0000_0004, 1'b0, 8'h00},
      '{1'b1, 8'h03, 2'h0, 32'h0000_0000, 1'b0, 8'h04},
      '{1'b1, 8'h06, 2'h0, 32'h0000_0000, 1'b0, 8'h04},
      '{1'b0, 8'h05, 2'h1, 32'h0000_0303, 1'b1, 8'h00},
      '{1'b0, 8'h07, 2'h0, 32'h0000_0001, 1'b1, 8'h00}};
    repeat (8) @(posedge ref_clk_in);
    chk({i_i2c_fn_if.scl, i_i2c_fn_if.sda_dev_oe, irq, susp_out, pready}, 5'h10);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    $display("reset test done");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(nk, 1'b1);
    apb(1'b1, `APB_CMD, 32'h0000_0105);
    apb(1'b1, `APB_CMD, 32'h0000_0105);
    chk(nk, 1'b1);
    wait_idle();
    $display("apb refusal test done");
    for (int i = 0; i < 8; i++) begin
      xfer(rows[i].rd, rows[i].sub, rows[i].len, rows[i].wdata);
      chk(nk, rows[i].nack);
      if (rows[i].rd) chk(rv[7:0], rows[i].rdata);
      $display("row %0d done", i);
    end
    pulse(3'h1);
    chk(txd, 8'h11);
    pulse(3'h2);
    chk(irq, 1'b1);
    xfer(1'b1, 8'h03, 2'h0, 32'h0000_0000);
    chk(rv[7:0], 8'h01);
    xfer(1'b0, 8'h03, 2'h0, 32'h0000_0001);
    chk(irq, 1'b0);
    $display("host ack test done");
    xfer(1'b0, 8'h00, 2'h3, 32'h8877_6655);
    chk(nk, 1'b0);
    xfer(1'b0, 8'h00, 2'h1, 32'h0000_aa99);
    chk({nk, irq}, 2'h3);
    xfer(1'b1, 8'h03, 2'h0, 32'h0000_0000);
    chk(rv[7:0], 8'h02);
    xfer(1'b0, 8'h02, 2'h0, 32'h0000_0001);
    xfer(1'b1, 8'h02, 2'h0, 32'h0000_0000);
    chk(rv[7:0], 8'h00);
    xfer(1'b1, 8'h06, 2'h0, 32'h0000_0000);
    chk(rv[7:0], 8'h00);
    xfer(1'b0, 8'h03, 2'h0, 32'h0000_0002);
    chk(irq, 1'b0);
    $display("overrun test done");
    pulse(3'h4);
    chk({irq, susp_out}, 2'h2);
    xfer(1'b0, 8'h04, 2'h0, 32'h0000_0002);
    chk(susp_out, 1'b1);
    repeat (6) begin
      @(posedge ref_clk_in);
      chk(dclk, 1'b0);
    end
    @(posedge ref_clk_in) wakeup <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    chk({rwake, susp_out}, 2'h1);
    @(posedge ref_clk_in) fen <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    chk(rwake, 1'b1);
    // divided clock runs again: toggles every second edge
    nk = dclk;
    repeat (2) @(posedge ref_clk_in);
    chk({susp_out, dclk}, {1'b0, ~nk});
    $display("suspend test done");
    xfer(1'b1, 8'h05, 2'h1, 32'h0000_0000);
    chk({nk, rv[15:0]}, 17'h0_0303);
    $display("multi-byte read test done");
    @(posedge ref_clk_in) arst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk({i_i2c_fn_if.scl, i_i2c_fn_if.sda_dev_oe, irq, susp_out, pready, dclk}, 6'h20);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    xfer(1'b1, 8'h05, 2'h0, 32'h0000_0000);
    chk({nk, rv[7:0]}, 9'h000);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
